// >>> tb/nvm_mem_model.sv
// memory array model behind the write stream and read port
`default_nettype none
module nvm_mem_model
   import hv_prog_pkg::*;
(
   input wire logic clock,
   input wire logic stall,
   input wire logic [11:0] nvm_read_addr,
   input wire logic nvm_read_eeprom,
   output logic [15:0] nvm_read_data,
   input wire logic nvm_valid,
   output logic nvm_ready,
   input wire nvm_op_t nvm_op
);
   logic [15:0] flash [4096];
   logic [7:0] ee [512];
   initial begin
      foreach (flash[i]) flash[i] = 16'hffff;
      foreach (ee[i]) ee[i] = 8'hff;
   end
   // a stalled array holds off the whole write stream
   assign nvm_ready = !stall;
   assign nvm_read_data = nvm_read_eeprom ? {8'hff, ee[nvm_read_addr[8:0]]} :
      flash[nvm_read_addr];
   always @(posedge clock) begin
      if (nvm_valid && nvm_ready) begin
         case (nvm_op.kind)
            OP_FLASH_WORD: flash[nvm_op.addr] <= nvm_op.data;
            OP_EE_BYTE: ee[nvm_op.addr[8:0]] <= nvm_op.data[7:0];
            OP_ERASE_FLASH: foreach (flash[i]) flash[i] <= 16'hffff;
            OP_ERASE_EE: foreach (ee[i]) ee[i] <= 8'hff;
            default: ;
         endcase
      end
   end
endmodule : nvm_mem_model
`default_nettype wire

// >>> tb/parallel_hv_memory_programmer_sva.sv
// checker for the programming port pins and write stream
`default_nettype none
module hv_prog_checker
   import hv_prog_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic high_voltage,
   input wire logic load_select_high,
   input wire logic load_select_low,
   input wire logic low_high_byte_select,
   input wire logic page_latch_strobe,
   input wire logic write_strobe_n,
   input wire logic output_enable_n,
   input wire logic data_oe,
   input wire logic ready_busy,
   input wire logic prog_mode,
   input wire logic nvm_valid,
   input wire logic nvm_ready,
   input wire nvm_op_t nvm_op
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   logic [11:0] hold_cnt_r;
   logic flash_gone_r;
   wire pat_zero = !(page_latch_strobe | load_select_high | load_select_low
      | low_high_byte_select);
   wire taken = nvm_valid && nvm_ready;
   // pin-level count runs ahead of the synchronised one, so it bounds from above
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         hold_cnt_r <= 12'h000;
      end else if (!(high_voltage && pat_zero)) begin
         hold_cnt_r <= 12'h000;
      end else if (hold_cnt_r != 12'hfff) begin
         hold_cnt_r <= hold_cnt_r + 12'h001;
      end
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         flash_gone_r <= 1'b0;
      end else if (taken) begin
         flash_gone_r <= (nvm_op.kind == OP_ERASE_FLASH) ||
            (flash_gone_r && nvm_op.kind != OP_CLEAR_LOCK);
      end
   end
   a_mode_entry: assert property ($rose(prog_mode) |-> hold_cnt_r >= 12'h7d0)
      else $error("programming mode entered without a held enable pattern");
   a_mode_exit: assert property (!high_voltage [*6] |-> !prog_mode)
      else $error("programming mode kept without high voltage");
   a_oe_released: assert property (output_enable_n [*6] |-> !data_oe)
      else $error("data bus driven with output enable high");
   a_no_mode_drive: assert property (!prog_mode [*6] |-> !data_oe)
      else $error("data bus driven outside programming mode");
   a_busy_write: assert property ($fell(write_strobe_n) && prog_mode && ready_busy
      |-> ##[2:6] !ready_busy) else $error("write pulse did not raise busy");
   a_busy_min: assert property ($fell(ready_busy) |-> !ready_busy [*8])
      else $error("busy dropped too early");
   a_op_hold: assert property (nvm_valid && !nvm_ready |=> nvm_valid && $stable(nvm_op))
      else $error("write op changed while stalled");
   a_busy_ops: assert property (nvm_valid |-> !ready_busy)
      else $error("ready shown with writes pending");
   a_lock_last: assert property (taken && nvm_op.kind == OP_CLEAR_LOCK |-> flash_gone_r)
      else $error("lock cleared before flash erase");
   c_erase: cover property (taken && nvm_op.kind == OP_CLEAR_LOCK);
   c_stall: cover property (nvm_valid && !nvm_ready);
   c_read: cover property ($rose(data_oe));
endmodule : hv_prog_checker
bind parallel_hv_memory_programmer hv_prog_checker u_chk (.clock(clock), .resetn(resetn),
   .high_voltage(high_voltage), .load_select_high(load_select_high),
   .load_select_low(load_select_low), .low_high_byte_select(low_high_byte_select),
   .page_latch_strobe(page_latch_strobe), .write_strobe_n(write_strobe_n),
   .output_enable_n(output_enable_n), .data_oe(data_oe), .ready_busy(ready_busy),
   .prog_mode(prog_mode), .nvm_valid(nvm_valid), .nvm_ready(nvm_ready), .nvm_op(nvm_op));
`default_nettype wire

// >>> tb/test_parallel_hv_memory_programmer.sv
// pin-level testbench of the programming port
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module test_parallel_hv_memory_programmer
   import hv_prog_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock, resetn, hv, strobe, sh, sl, bsel, ext, pl, wr_n, oe_n, fuse, stall;
   logic data_oe, ready_busy, prog_mode, rd_ee, nvm_valid, nvm_ready;
   logic [7:0] din, data_out;
   logic [11:0] rd_addr;
   logic [15:0] rd_data;
   nvm_op_t nvm_op;
   nvm_op_t ops[$];
   int n_fail = 0;
   int total_checks = 0;
   nvm_kind_t erase_seq[2][3] = '{'{OP_ERASE_FLASH, OP_ERASE_EE, OP_CLEAR_LOCK},
      '{OP_ERASE_FLASH, OP_CLEAR_LOCK, OP_CLEAR_LOCK}};
   wire [7:0] bus;
   // shared data wire: device wins while it drives
   assign bus = data_oe ? data_out : din;
   parallel_hv_memory_programmer #(.PAGE_PROG_CYCLES(50), .CHIP_ERASE_CYCLES(100)) dut (
      .clock(clock), .resetn(resetn), .high_voltage(hv), .load_strobe(strobe),
      .load_select_high(sh), .load_select_low(sl), .low_high_byte_select(bsel),
      .extended_byte_select(ext), .page_latch_strobe(pl), .write_strobe_n(wr_n),
      .output_enable_n(oe_n), .data_in(bus), .data_out(data_out), .data_oe(data_oe),
      .ready_busy(ready_busy), .prog_mode(prog_mode), .eeprom_preserve_fuse(fuse),
      .nvm_read_addr(rd_addr), .nvm_read_eeprom(rd_ee), .nvm_read_data(rd_data),
      .nvm_valid(nvm_valid), .nvm_ready(nvm_ready), .nvm_op(nvm_op));
   nvm_mem_model mem (.clock(clock), .stall(stall), .nvm_read_addr(rd_addr),
      .nvm_read_eeprom(rd_ee), .nvm_read_data(rd_data), .nvm_valid(nvm_valid),
      .nvm_ready(nvm_ready), .nvm_op(nvm_op));
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock) if (nvm_valid && nvm_ready) ops.push_back(nvm_op);
   task step(input int n);
      repeat (n) @(posedge clock);
   endtask : step
   task final_report;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   task wait_sig(input int k, input logic v, input int lim);
      for (int i = 0; i < lim; i++) begin
         if ((k ? prog_mode : ready_busy) === v) return;
         step(1);
      end
      n_fail++;
      $display("wait timed out at %0t", $time);
      final_report;
   endtask : wait_sig
   // 195 ns load period: strobe high 12 clocks, low 27
   task load(input logic [1:0] s, input logic b, input logic [7:0] v);
      {sh, sl} <= s;
      bsel <= b;
      din <= v;
      step(13);
      strobe <= 1'b1;
      step(12);
      strobe <= 1'b0;
      step(13);
      // idle select, then let an edge pass before the next call drives it
      {sh, sl} <= 2'b11;
      step(1);
   endtask : load
   task latch;
      bsel <= 1'b1;
      pl <= 1'b1;
      step(13);
      pl <= 1'b0;
      step(13);
   endtask : latch
   task write(input logic b);
      bsel <= b;
      step(13);
      wr_n <= 1'b0;
      step(13);
      `CHK(ready_busy, 1'b0);
      wr_n <= 1'b1;
      step(13);
   endtask : write
   task rd(input logic b, input logic [7:0] e);
      bsel <= b;
      oe_n <= 1'b0;
      step(13);
      `CHK(data_oe, 1'b1);
      `CHK(data_out, e);
      oe_n <= 1'b1;
      step(13);
      `CHK(data_oe, 1'b0);
   endtask : rd
   initial begin
      resetn = 1'b0; hv = 1'b0; strobe = 1'b0; sh = 1'b0; sl = 1'b0; bsel = 1'b0;
      ext = 1'b0; pl = 1'b0; wr_n = 1'b1; oe_n = 1'b1; din = 8'h00; fuse = 1'b0;
      stall = 1'b0;
      step(8);
      resetn <= 1'b1;
      step(4);
      `CHK(prog_mode, 1'b0);
      // nonzero enable pattern at high voltage must not enter the mode
      sh <= 1'b1;
      hv <= 1'b1;
      step(2100);
      `CHK(prog_mode, 1'b0);
      hv <= 1'b0;
      sh <= 1'b0;
      step(4);
      hv <= 1'b1;
      wait_sig(1, 1'b1, 2100);
      `CHK(ready_busy, 1'b1);
      {sh, sl} <= 2'b11;
      step(60000);
      $display("test mode entry done");
      for (int f = 1; f >= 0; f--) begin
         ops.delete();
         fuse <= f[0];
         load(2'b10, 1'b0, 8'h80);
         write(1'b0);
         wait_sig(0, 1'b1, 3000);
         `CHK(ops.size(), 3 - f);
         foreach (ops[i]) if (i < 3) `CHK(ops[i].kind, erase_seq[f][i]);
      end
      $display("test chip erase done");
      ops.delete();
      load(2'b10, 1'b0, 8'h10);
      load(2'b00, 1'b1, 8'h01);
      load(2'b00, 1'b0, 8'h23);
      load(2'b01, 1'b0, 8'h34);
      load(2'b01, 1'b1, 8'h12);
      latch;
      load(2'b00, 1'b0, 8'h3f);
      load(2'b01, 1'b0, 8'hcd);
      load(2'b01, 1'b1, 8'hab);
      latch;
      stall <= 1'b1;
      write(1'b0);
      step(60);
      `CHK(nvm_valid, 1'b1);
      stall <= 1'b0;
      wait_sig(0, 1'b1, 3000);
      `CHK(ops.size(), 32);
      foreach (ops[i]) begin
         `CHK(ops[i].kind, OP_FLASH_WORD);
         `CHK(ops[i].addr, 12'h120 + 12'(i));
         `CHK(ops[i].data, i == 3 ? 16'h1234 : i == 31 ? 16'habcd : 16'hffff);
      end
      load(2'b10, 1'b0, 8'h00);
      $display("test flash page done");
      load(2'b10, 1'b0, 8'h02);
      load(2'b00, 1'b0, 8'h23);
      rd(1'b0, 8'h34);
      rd(1'b1, 8'h12);
      load(2'b00, 1'b0, 8'h3f);
      rd(1'b0, 8'hcd);
      rd(1'b1, 8'hab);
      $display("test flash read done");
      ops.delete();
      load(2'b10, 1'b0, 8'h11);
      load(2'b00, 1'b1, 8'h00);
      load(2'b00, 1'b0, 8'h05);
      load(2'b01, 1'b0, 8'h5a);
      latch;
      write(1'b0);
      wait_sig(0, 1'b1, 3000);
      `CHK(ops.size(), 4);
      foreach (ops[i]) begin
         `CHK(ops[i].kind, OP_EE_BYTE);
         `CHK(ops[i].addr, 12'h004 + 12'(i));
         `CHK(ops[i].data[7:0], i == 1 ? 8'h5a : 8'hff);
      end
      load(2'b10, 1'b0, 8'h03);
      rd(1'b0, 8'h5a);
      $display("test eeprom page done");
      hv <= 1'b0;
      wait_sig(1, 1'b0, 20);
      `CHK(prog_mode, 1'b0);
      $display("test mode exit done");
      final_report;
   end
endmodule : test_parallel_hv_memory_programmer
`default_nettype wire

// >>> verilog/hv_prog_map.svh
// offsets, command codes, reset values and timing counts of the programming port
`ifndef HV_PROG_MAP_SVH
`define HV_PROG_MAP_SVH

`define CLK_PERIOD_NS 5
`define ENABLE_HOLD_NS 10000
`define ENABLE_HOLD_CYCLES ((`ENABLE_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PAGE_PROG_NS 3700000
`define PAGE_PROG_CYCLES ((`PAGE_PROG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CHIP_ERASE_NS 7500000
`define CHIP_ERASE_CYCLES ((`CHIP_ERASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define CMD_NOP 8'h00
`define CMD_CHIP_ERASE 8'h80
`define CMD_WRITE_FLASH 8'h10
`define CMD_WRITE_EEPROM 8'h11
`define CMD_READ_FLASH 8'h02
`define CMD_READ_EEPROM 8'h03

`define SEL_ADDRESS 2'h0
`define SEL_DATA 2'h1
`define SEL_COMMAND 2'h2

`define ENABLE_PATTERN 4'h0
`define FLASH_WORD_BITS 5
`define EE_BYTE_BITS 2
`define FLASH_ADDR_BITS 12
`define EE_ADDR_BITS 9
`define ERASED_WORD 16'hffff

`endif

// >>> verilog/hv_prog_pkg.sv
// types shared by the programming port and its write queue
`default_nettype none
package hv_prog_pkg;
   typedef enum logic [2:0] {
      OP_FLASH_WORD,
      OP_EE_BYTE,
      OP_ERASE_FLASH,
      OP_ERASE_EE,
      OP_CLEAR_LOCK
   } nvm_kind_t;

   typedef struct packed {
      nvm_kind_t kind;
      logic [11:0] addr;
      logic [15:0] data;
   } nvm_op_t;

   typedef struct packed {
      logic hv;
      logic strobe;
      logic sel_high;
      logic sel_low;
      logic byte_sel;
      logic ext_sel;
      logic page_latch;
      logic write_n;
      logic oe_n;
      logic [7:0] data;
   } pin_in_t;
endpackage : hv_prog_pkg
`default_nettype wire

// >>> verilog/parallel_hv_memory_programmer.sv
// parallel high-voltage programming port with its write queue
`default_nettype none
`include "hv_prog_map.svh"

module op_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wr_ptr_r;
   logic [AW:0] rd_ptr_r;
   wire logic full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
   wire logic empty = (wr_ptr_r == rd_ptr_r);
   wire logic push = in_valid && !full;
   wire logic pop = out_ready && !empty;

   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem_r[rd_ptr_r[AW-1:0]];

   always_ff @(posedge clock) begin
      if (push) begin
         mem_r[wr_ptr_r[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
         if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
      end
   end
endmodule : op_fifo

module parallel_hv_memory_programmer
   import hv_prog_pkg::*;
#(
   parameter int unsigned PAGE_PROG_CYCLES = `PAGE_PROG_CYCLES,
   parameter int unsigned CHIP_ERASE_CYCLES = `CHIP_ERASE_CYCLES,
   parameter int QUEUE_DEPTH = 32
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic high_voltage,
   input wire logic load_strobe,
   input wire logic load_select_high,
   input wire logic load_select_low,
   input wire logic low_high_byte_select,
   input wire logic extended_byte_select,
   input wire logic page_latch_strobe,
   input wire logic write_strobe_n,
   input wire logic output_enable_n,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   output logic ready_busy,
   output logic prog_mode,
   input wire logic eeprom_preserve_fuse,
   output logic [11:0] nvm_read_addr,
   output logic nvm_read_eeprom,
   input wire logic [15:0] nvm_read_data,
   output logic nvm_valid,
   input wire logic nvm_ready,
   output nvm_op_t nvm_op
);
   localparam int CNT_W = $clog2(CHIP_ERASE_CYCLES + 1);
   localparam int FW = `FLASH_WORD_BITS;
   localparam int EW = `EE_BYTE_BITS;
   localparam int FWORDS = 1 << FW;
   localparam int EBYTES = 1 << EW;
   localparam logic [12:0] HOLD_CYCLES = 13'(`ENABLE_HOLD_CYCLES);

   typedef enum {ST_IDLE, ST_PUSH_FLASH, ST_PUSH_EE, ST_PUSH_ERASE, ST_WAIT} wr_state_t;

   // pin synchroniser: the first stage is read only by the second
   pin_in_t pins;
   pin_in_t sync1_r;
   pin_in_t sync2_r;
   pin_in_t prev_r;
   assign pins = '{hv: high_voltage, strobe: load_strobe, sel_high: load_select_high,
                   sel_low: load_select_low, byte_sel: low_high_byte_select,
                   ext_sel: extended_byte_select, page_latch: page_latch_strobe,
                   write_n: write_strobe_n, oe_n: output_enable_n, data: data_in};

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sync1_r <= '0;
         sync2_r <= '0;
         prev_r <= '0;
      end else begin
         sync1_r <= pins;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
      end
   end

   // edges; prev starts at zero so reset never fakes a write fall
   wire logic strobe_rise = sync2_r.strobe && !prev_r.strobe;
   wire logic latch_rise = sync2_r.page_latch && !prev_r.page_latch;
   wire logic write_fall = prev_r.write_n && !sync2_r.write_n;
   wire logic hv_rise = sync2_r.hv && !prev_r.hv;
   wire logic [3:0] pattern = {sync2_r.page_latch, sync2_r.sel_high, sync2_r.sel_low,
                               sync2_r.byte_sel};
   wire logic [1:0] load_sel = {sync2_r.sel_high, sync2_r.sel_low};

   // mode entry
   logic prog_mode_r;
   logic holding_r;
   logic [12:0] hold_cnt_r;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         prog_mode_r <= 1'b0;
         holding_r <= 1'b0;
         hold_cnt_r <= '0;
      end else if (!sync2_r.hv) begin
         prog_mode_r <= 1'b0;
         holding_r <= 1'b0;
      end else if (hv_rise) begin
         holding_r <= (pattern == `ENABLE_PATTERN);
         hold_cnt_r <= HOLD_CYCLES;
      end else if (holding_r) begin
         if (pattern != `ENABLE_PATTERN) begin
            holding_r <= 1'b0;
         end else if (hold_cnt_r == 13'h1) begin
            holding_r <= 1'b0;
            prog_mode_r <= 1'b1;
         end else begin
            hold_cnt_r <= hold_cnt_r - 13'h1;
         end
      end
   end

   // load path; address persists until overwritten, command until overwritten or the mode ends
   logic [7:0] cmd_r;
   logic [7:0] addr_lo_r;
   logic [7:0] addr_hi_r;
   logic [7:0] data_lo_r;
   logic [7:0] data_hi_r;
   wire logic do_load = prog_mode_r && strobe_rise;
   wire logic [15:0] full_addr = {addr_hi_r, addr_lo_r};

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cmd_r <= `CMD_NOP;
         addr_lo_r <= '0;
         addr_hi_r <= '0;
         data_lo_r <= '0;
         data_hi_r <= '0;
      end else if (!prog_mode_r) begin
         cmd_r <= `CMD_NOP;
      end else if (do_load) begin
         if (load_sel == `SEL_ADDRESS && !sync2_r.byte_sel) addr_lo_r <= sync2_r.data;
         else if (load_sel == `SEL_ADDRESS) addr_hi_r <= sync2_r.data;
         else if (load_sel == `SEL_DATA && !sync2_r.byte_sel) data_lo_r <= sync2_r.data;
         else if (load_sel == `SEL_DATA) data_hi_r <= sync2_r.data;
         else if (load_sel == `SEL_COMMAND) cmd_r <= sync2_r.data;
      end
   end

   // page buffers; fresh entries read as erased so unlatched words stay blank
   logic [15:0] flash_buf_r [FWORDS];
   logic [7:0] ee_buf_r [EBYTES];
   logic buf_clear;
   wire logic do_latch = prog_mode_r && latch_rise;
   wire logic [FW-1:0] word_sel = full_addr[FW-1:0];
   wire logic [EW-1:0] ee_sel = full_addr[EW-1:0];

   genvar gi;
   generate
      for (gi = 0; gi < FWORDS; gi++) begin : g_flash_buf
         always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) flash_buf_r[gi] <= `ERASED_WORD;
            else if (buf_clear) flash_buf_r[gi] <= `ERASED_WORD;
            else if (do_latch && cmd_r == `CMD_WRITE_FLASH && word_sel == FW'(gi))
               flash_buf_r[gi] <= {data_hi_r, data_lo_r};
         end
      end
      for (gi = 0; gi < EBYTES; gi++) begin : g_ee_buf
         always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) ee_buf_r[gi] <= 8'hff;
            else if (buf_clear) ee_buf_r[gi] <= 8'hff;
            else if (do_latch && cmd_r == `CMD_WRITE_EEPROM && ee_sel == EW'(gi))
               ee_buf_r[gi] <= data_lo_r;
         end
      end
   endgenerate

   // write sequencer feeding the queue
   wr_state_t state_r;
   wr_state_t state_nxt;
   logic [FW-1:0] idx_r;
   logic [CNT_W-1:0] timer_r;
   logic busy_r;
   logic q_in_valid;
   logic q_in_ready;
   nvm_op_t q_in_op;
   logic q_out_valid;
   nvm_op_t q_out_op;
   wire logic q_out_ready = !nvm_valid || nvm_ready;

   wire logic start_flash = write_fall && cmd_r == `CMD_WRITE_FLASH;
   wire logic start_ee = write_fall && cmd_r == `CMD_WRITE_EEPROM && !sync2_r.byte_sel;
   wire logic start_erase = write_fall && cmd_r == `CMD_CHIP_ERASE;
   wire logic can_start = prog_mode_r && state_r == ST_IDLE;
   wire logic [11:0] page_base = {full_addr[11:FW], {FW{1'b0}}};
   wire logic [11:0] ee_base = {3'h0, full_addr[8:EW], {EW{1'b0}}};
   wire logic last_flash = idx_r == FW'(FWORDS - 1);
   wire logic last_ee = idx_r == FW'(EBYTES - 1);
   wire logic last_erase = idx_r == FW'(2);
   wire logic skip_ee_erase = state_r == ST_PUSH_ERASE && idx_r == FW'(1)
                              && eeprom_preserve_fuse;
   wire nvm_kind_t erase_kind = idx_r == FW'(0) ? OP_ERASE_FLASH
                              : idx_r == FW'(1) ? OP_ERASE_EE : OP_CLEAR_LOCK;

   assign q_in_valid = (state_r == ST_PUSH_FLASH || state_r == ST_PUSH_EE
                        || state_r == ST_PUSH_ERASE) && !skip_ee_erase;
   assign q_in_op.kind = state_r == ST_PUSH_FLASH ? OP_FLASH_WORD
                       : state_r == ST_PUSH_EE ? OP_EE_BYTE : erase_kind;
   assign q_in_op.addr = state_r == ST_PUSH_FLASH ? (page_base | 12'(idx_r))
                       : state_r == ST_PUSH_EE ? (ee_base | 12'(idx_r)) : 12'h0;
   assign q_in_op.data = state_r == ST_PUSH_FLASH ? flash_buf_r[idx_r]
                       : state_r == ST_PUSH_EE ? {8'h0, ee_buf_r[idx_r[EW-1:0]]} : 16'h0;
   wire logic step = q_in_ready || skip_ee_erase;
   wire logic done_wait = timer_r == '0 && !q_out_valid && !nvm_valid;
   assign buf_clear = state_r == ST_WAIT && done_wait || prog_mode_r && do_load
                      && load_sel == `SEL_COMMAND && sync2_r.data == `CMD_NOP;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (can_start && start_flash) state_nxt = ST_PUSH_FLASH;
            else if (can_start && start_ee) state_nxt = ST_PUSH_EE;
            else if (can_start && start_erase) state_nxt = ST_PUSH_ERASE;
         end
         ST_PUSH_FLASH: begin
            if (step && last_flash) state_nxt = ST_WAIT;
         end
         ST_PUSH_EE: begin
            if (step && last_ee) state_nxt = ST_WAIT;
         end
         ST_PUSH_ERASE: begin
            if (step && last_erase) state_nxt = ST_WAIT;
         end
         ST_WAIT: begin
            if (done_wait) state_nxt = ST_IDLE;
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_r <= ST_IDLE;
         idx_r <= '0;
      end else begin
         state_r <= state_nxt;
         if (state_nxt != state_r) idx_r <= '0;
         else if (step) idx_r <= idx_r + 1'b1;
      end
   end

   // busy holds for the programming time and until the queue has drained
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         timer_r <= '0;
         busy_r <= 1'b0;
      end else if (can_start && (start_flash || start_ee)) begin
         timer_r <= CNT_W'(PAGE_PROG_CYCLES);
         busy_r <= 1'b1;
      end else if (can_start && start_erase) begin
         timer_r <= CNT_W'(CHIP_ERASE_CYCLES);
         busy_r <= 1'b1;
      end else begin
         if (timer_r != '0) timer_r <= timer_r - 1'b1;
         if (state_r == ST_WAIT && done_wait) busy_r <= 1'b0;
      end
   end

   op_fifo #(.WIDTH($bits(nvm_op_t)), .DEPTH(QUEUE_DEPTH)) u_queue (
      .clock(clock),
      .resetn(resetn),
      .in_valid(q_in_valid),
      .in_ready(q_in_ready),
      .in_data(q_in_op),
      .out_valid(q_out_valid),
      .out_ready(q_out_ready),
      .out_data(q_out_op)
   );

   // output stage so the memory port comes from flops
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         nvm_valid <= 1'b0;
         nvm_op <= '0;
      end else if (q_out_ready) begin
         nvm_valid <= q_out_valid;
         nvm_op <= q_out_op;
      end
   end

   // read path; memory read data arrives on this clock in the same cycle as the address
   wire logic read_cmd = cmd_r == `CMD_READ_FLASH || cmd_r == `CMD_READ_EEPROM;
   wire logic [7:0] read_byte = (sync2_r.byte_sel && cmd_r == `CMD_READ_FLASH)
                              ? nvm_read_data[15:8] : nvm_read_data[7:0];

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         nvm_read_addr <= '0;
         nvm_read_eeprom <= 1'b0;
         data_out <= '0;
         data_oe <= 1'b0;
         ready_busy <= 1'b1;
         prog_mode <= 1'b0;
      end else begin
         nvm_read_addr <= cmd_r == `CMD_READ_EEPROM ? {3'h0, full_addr[8:0]} : full_addr[11:0];
         nvm_read_eeprom <= cmd_r == `CMD_READ_EEPROM;
         data_out <= read_byte;
         data_oe <= prog_mode_r && !sync2_r.oe_n && read_cmd;
         ready_busy <= !(busy_r || state_nxt != ST_IDLE);
         prog_mode <= prog_mode_r;
      end
   end
endmodule : parallel_hv_memory_programmer
`default_nettype wire
